//--- design/mct_pkg.sv
// constants and helpers shared by the counter/timer design
package mct_pkg;

	localparam int NUM_MATCH = 4;
	localparam int NUM_CAP   = 2;
	localparam int ADDR_W    = 8;

	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PRESC    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PCNT     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MCTRL    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MATCH0   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CCTRL    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_CAP0     = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_EMCTRL   = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_EMOUT    = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h3c;

	// control register fields
	localparam int CTRL_EN   = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CTRL_MODE = 2;
	localparam int CTRL_EDGE = 3;
	localparam int CTRL_SRC  = 5;
	localparam int CTRL_W    = 6;

	// match control: three bits per match
	localparam int MC_INT    = 0;
	localparam int MC_RST    = 1;
	localparam int MC_STOP   = 2;
	localparam int MC_STRIDE = 3;

	// capture control: three bits per channel, then clear select
	localparam int CC_RISE   = 0;
	localparam int CC_INT    = 2;
	localparam int CC_STRIDE = 3;
	localparam int CC_CLR_EN = 6;
	localparam int CC_CLR_SEL = 7;

	// interrupt status layout
	localparam int IRQ_CAP = 4;
	localparam int IRQ_W   = 6;

	localparam logic [31:0] RST_VAL = 32'h0000_0000;

	typedef enum logic [1:0] {
		EM_NONE   = 2'b00,
		EM_LOW    = 2'b01,
		EM_HIGH   = 2'b10,
		EM_TOGGLE = 2'b11
	} em_act_e;

	function automatic logic [ADDR_W-1:0] reg_ofs(
		input logic [ADDR_W-1:0] base,
		input int                idx
	);
		return base + ADDR_W'(4 * idx);
	endfunction

endpackage

//--- design/cap_edge.sv
// pin synchroniser with rise and fall pulses
`timescale 1ns/1ps
module cap_edge
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;
endmodule

//--- design/match_pin.sv
// one external match output with its match action
`timescale 1ns/1ps
module match_pin
	import mct_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	input  wire logic    hit,
	input  em_act_e      act,
	input  wire logic    wr,
	input  wire logic    wval,
	output logic         pin
);
	logic pin_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_q <= 1'b0;
		else if (hit)
		begin
			unique case (act)
				EM_NONE:   pin_q <= pin_q;   // [R8]
				EM_LOW:    pin_q <= 1'b0;    // [R8]
				EM_HIGH:   pin_q <= 1'b1;    // [R8]
				EM_TOGGLE: pin_q <= ~pin_q;  // [R8]
			endcase
		end
		else if (wr)
			pin_q <= wval;
	end

	assign pin = pin_q;

	a_pin_action: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		hit && act == EM_TOGGLE |=> pin_q != $past(pin_q))
		else $error("match output did not toggle");
endmodule

//--- design/match_capture_counter_timer.sv
// counter/timer with prescaler, four matches and two captures
`timescale 1ns/1ps
// Notes on behaviour
// R1: the block is built four times, twice 32 bits wide and twice 16 bits.
// R2: in timer mode the counter advances on clock cycles via the prescaler.
// R3: the prescaler is programmable and as wide as the counter.
// R4: a counter mode counts edges of a selected input instead of clocks.
// R5: four match values are compared; a plain match runs on, may interrupt.
// R6: a match set to stop halts the counter at the match value.
// R7: a match set to reset returns the counter to zero.
// R8: each match drives an output that goes low, high, toggles or holds.
// R9: two capture channels copy the count on a transition of their input.
// R10: a capture may raise an interrupt when enabled for that channel.
// R11: a chosen capture event may clear both the counter and the prescaler.
// R12: the prescaler steps each enabled clock, or each selected edge in counter mode, and on its limit wraps and ticks.
module match_capture_counter_timer
	import mct_pkg::*;
#(
	parameter int WIDTH = 32 // [R1]
)
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [31:0]          rdata,
	input  wire logic [NUM_CAP-1:0]   cap_in,
	output logic      [NUM_MATCH-1:0] match_out,
	output logic                      irq
);

	function automatic logic edge_hit(
		input logic       r,
		input logic       f,
		input logic [1:0] sel
	);
		return (r & sel[0]) | (f & sel[1]);
	endfunction

	logic                rs1_q;
	logic                rsn;
	logic [CTRL_W-1:0]   ctrl_q;
	logic [WIDTH-1:0]    tc_q;
	logic [WIDTH-1:0]    pr_q;
	logic [WIDTH-1:0]    pc_q;
	logic [11:0]         mctrl_q;
	logic [WIDTH-1:0]    mr_q [NUM_MATCH];
	logic [7:0]          cctrl_q;
	logic [WIDTH-1:0]    cap_q [NUM_CAP];
	logic [7:0]          emctrl_q;
	logic [IRQ_W-1:0]    stat_q;
	logic [IRQ_W-1:0]    mask_q;
	logic [31:0]         rdata_q;
	logic [31:0]         rmux;
	logic [NUM_CAP-1:0]  rise;
	logic [NUM_CAP-1:0]  fall;
	logic [NUM_CAP-1:0]  cap_evt;
	logic [NUM_MATCH-1:0] hit;
	logic [NUM_MATCH-1:0] hit_rst;
	logic [NUM_MATCH-1:0] hit_stop;
	logic [NUM_MATCH-1:0] hit_int;
	logic [IRQ_W-1:0]    stat_set;
	logic                count_ev;
	logic                en;
	logic                hold;
	logic                step;
	logic                tick;
	logic                any_rst;
	logic                any_stop;
	logic                clr;
	logic                wr_ctrl;
	logic                wr_count;
	logic                wr_pcnt;
	logic                wr_emout;
	logic                rd_stat;

	// reset release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_q <= 1'b0;
			rsn   <= 1'b0;
		end
		else
		begin
			rs1_q <= 1'b1;
			rsn   <= rs1_q;
		end
	end

	// capture pins
	for (genvar c = 0; c < NUM_CAP; c++)
	begin : g_cap
		cap_edge u_edge (
			.clk   (clk),
			.rst_n (rsn),
			.pin   (cap_in[c]),
			.rise  (rise[c]),
			.fall  (fall[c])
		);
		assign cap_evt[c] = edge_hit(rise[c], fall[c],
			cctrl_q[c*CC_STRIDE+CC_RISE +: 2]); // [R9]
	end

	// write decode and status read decode
	assign wr_ctrl  = wr && addr == OFS_CTRL;
	assign wr_count = wr && addr == OFS_COUNT;
	assign wr_pcnt  = wr && addr == OFS_PCNT;
	assign wr_emout = wr && addr == OFS_EMOUT;
	assign rd_stat  = rd && addr == OFS_IRQ_STAT;

	// count stepping
	assign en   = ctrl_q[CTRL_EN];
	assign hold = ctrl_q[CTRL_HOLD];
	assign count_ev = edge_hit(rise[ctrl_q[CTRL_SRC]],
		fall[ctrl_q[CTRL_SRC]], ctrl_q[CTRL_EDGE +: 2]); // [R4]
	assign step = en && !hold
		&& (ctrl_q[CTRL_MODE] ? count_ev : 1'b1); // [R2] [R4]
	assign tick = step && pc_q == pr_q; // [R12]

	// match compare
	for (genvar i = 0; i < NUM_MATCH; i++)
	begin : g_match
		assign hit[i]      = tick && tc_q == mr_q[i]; // [R5]
		assign hit_int[i]  = hit[i] && mctrl_q[i*MC_STRIDE+MC_INT];
		assign hit_rst[i]  = hit[i] && mctrl_q[i*MC_STRIDE+MC_RST];
		assign hit_stop[i] = hit[i] && mctrl_q[i*MC_STRIDE+MC_STOP];

		match_pin u_pin (
			.clk   (clk),
			.rst_n (rsn),
			.hit   (hit[i]),
			.act   (em_act_e'(emctrl_q[2*i +: 2])), // [R8]
			.wr    (wr_emout),
			.wval  (wdata[i]),
			.pin   (match_out[i])
		);
	end

	assign any_rst  = |hit_rst;
	assign any_stop = |hit_stop;
	assign clr = cctrl_q[CC_CLR_EN]
		&& cap_evt[cctrl_q[CC_CLR_SEL]]; // [R11]

	// control, stop on match clears enable
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
			ctrl_q <= RST_VAL[CTRL_W-1:0];
		else if (any_stop)
			ctrl_q[CTRL_EN] <= 1'b0; // [R6]
		else if (wr_ctrl)
			ctrl_q <= wdata[CTRL_W-1:0];
	end

	// main counter
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
			tc_q <= RST_VAL[WIDTH-1:0];
		else if (wr_count)
			tc_q <= wdata[WIDTH-1:0];
		else if (clr || hold)
			tc_q <= '0; // [R11]
		else if (tick)
		begin
			if (any_rst)
				tc_q <= '0; // [R7]
			else if (any_stop)
				tc_q <= tc_q; // [R6]
			else
				tc_q <= tc_q + 1'b1; // [R2] [R5]
		end
	end

	// prescale counter
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
			pc_q <= RST_VAL[WIDTH-1:0];
		else if (wr_pcnt)
			pc_q <= wdata[WIDTH-1:0];
		else if (clr || hold)
			pc_q <= '0; // [R11]
		else if (tick)
			pc_q <= '0; // [R12]
		else if (step)
			pc_q <= pc_q + 1'b1; // [R12]
	end

	// configuration registers
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
		begin
			pr_q     <= RST_VAL[WIDTH-1:0];
			mctrl_q  <= RST_VAL[11:0];
			cctrl_q  <= RST_VAL[7:0];
			emctrl_q <= RST_VAL[7:0];
			mask_q   <= RST_VAL[IRQ_W-1:0];
		end
		else if (wr)
		begin
			if (addr == OFS_PRESC)
				pr_q <= wdata[WIDTH-1:0]; // [R3]
			if (addr == OFS_MCTRL)
				mctrl_q <= wdata[11:0];
			if (addr == OFS_CCTRL)
				cctrl_q <= wdata[7:0];
			if (addr == OFS_EMCTRL)
				emctrl_q <= wdata[7:0];
			if (addr == OFS_IRQ_MASK)
				mask_q <= wdata[IRQ_W-1:0];
		end
	end

	// match values
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
		begin
			for (int i = 0; i < NUM_MATCH; i++)
				mr_q[i] <= RST_VAL[WIDTH-1:0];
		end
		else
		begin
			for (int i = 0; i < NUM_MATCH; i++)
				if (wr && addr == reg_ofs(OFS_MATCH0, i))
					mr_q[i] <= wdata[WIDTH-1:0];
		end
	end

	// capture registers
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
		begin
			for (int c = 0; c < NUM_CAP; c++)
				cap_q[c] <= RST_VAL[WIDTH-1:0];
		end
		else
		begin
			for (int c = 0; c < NUM_CAP; c++)
				if (cap_evt[c])
					cap_q[c] <= tc_q; // [R9]
		end
	end

	// sticky status, set wins over read clear
	always_comb
	begin
		stat_set = '0;
		stat_set[NUM_MATCH-1:0] = hit_int; // [R5] [R6] [R7]
		for (int c = 0; c < NUM_CAP; c++)
			stat_set[IRQ_CAP+c] = cap_evt[c]
				&& cctrl_q[c*CC_STRIDE+CC_INT]; // [R10]
	end

	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
			stat_q <= RST_VAL[IRQ_W-1:0];
		else
			stat_q <= (rd_stat ? '0 : stat_q) | stat_set;
	end

	assign irq = |(stat_q & mask_q);

	// read mux
	always_comb
	begin
		rmux = '0;
		case (addr)
			OFS_CTRL:     rmux = 32'(ctrl_q);
			OFS_COUNT:    rmux = 32'(tc_q);
			OFS_PRESC:    rmux = 32'(pr_q);
			OFS_PCNT:     rmux = 32'(pc_q);
			OFS_MCTRL:    rmux = 32'(mctrl_q);
			OFS_CCTRL:    rmux = 32'(cctrl_q);
			OFS_EMCTRL:   rmux = 32'(emctrl_q);
			OFS_EMOUT:    rmux = 32'(match_out);
			OFS_IRQ_STAT: rmux = 32'(stat_q);
			OFS_IRQ_MASK: rmux = 32'(mask_q);
			default:      rmux = '0;
		endcase
		for (int i = 0; i < NUM_MATCH; i++)
			if (addr == reg_ofs(OFS_MATCH0, i))
				rmux = 32'(mr_q[i]);
		for (int c = 0; c < NUM_CAP; c++)
			if (addr == reg_ofs(OFS_CAP0, c))
				rmux = 32'(cap_q[c]);
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge clk or negedge rsn)
	begin
		if (!rsn)
			rdata_q <= RST_VAL;
		else
			rdata_q <= rd ? rmux : '0;
	end

	assign rdata = rdata_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rsn);

	sequence s_stopped;
		!ctrl_q[CTRL_EN] && tc_q == $past(tc_q);
	endsequence

	sequence s_cleared;
		tc_q == '0 && pc_q == '0;
	endsequence

	a_presc_count: assert property ( // [R2] [R3] [R12]
		step && pc_q != pr_q && !clr && !wr_pcnt && !wr_count
		|=> pc_q == $past(pc_q) + 1'b1 && $stable(tc_q))
		else $error("prescaler did not step alone");

	a_presc_wrap: assert property ( // [R12]
		tick && !any_rst && !any_stop && !clr && !wr_count && !wr_pcnt
		|=> pc_q == '0 && tc_q == $past(tc_q) + 1'b1)
		else $error("prescaler wrap did not advance count");

	a_event_gate: assert property ( // [R4]
		en && ctrl_q[CTRL_MODE] && !count_ev && !clr && !hold
		&& !wr_count && !wr_pcnt
		|=> $stable(tc_q) && $stable(pc_q))
		else $error("counter mode moved without an event");

	a_match_irq: assert property ( // [R5]
		hit[0] && mctrl_q[MC_INT] |=> stat_q[0])
		else $error("match interrupt flag not set");

	a_match_stop: assert property ( // [R6]
		any_stop && !wr_count && !clr && !hold |=> s_stopped)
		else $error("stop on match did not halt");

	a_match_reset: assert property ( // [R7]
		tick && any_rst && !wr_count |=> tc_q == '0)
		else $error("reset on match did not clear count");

	a_cap_copy: assert property ( // [R9]
		cap_evt[1] |=> cap_q[1] == $past(tc_q))
		else $error("capture did not copy count");

	a_cap_irq: assert property ( // [R10]
		cap_evt[0] && cctrl_q[CC_INT] |=> stat_q[IRQ_CAP] ##1 1'b1)
		else $error("capture interrupt flag not set");

	a_cap_clear: assert property ( // [R11]
		clr && !wr_count && !wr_pcnt |=> s_cleared)
		else $error("capture clear missed");

endmodule

//--- verif/pin_side.sv
// far-side model driving the capture pins
`timescale 1ns/1ps
module pin_side
(
	input  wire logic       clk,
	output logic      [1:0] cap_in
);
	initial cap_in = 2'b00;

	// idle low pulse on selected pins, gap sets prompt or slow start
	task automatic pulse(input logic [1:0] m, input int w, input int gap);
		@(posedge clk);
		repeat (gap) @(posedge clk);
		cap_in <= cap_in | m;
		repeat (w) @(posedge clk);
		cap_in <= cap_in & ~m;
		repeat (4) @(posedge clk);
	endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the counter/timer
`timescale 1ns/1ps
module tb
	import mct_pkg::*;
;
	typedef struct packed
	{
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] e;
	} row_s;

	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [31:0]       rdata;
	logic [1:0]        cap_in;
	logic [3:0]        match_out;
	logic              irq;
	logic [31:0]       d;
	int                err_total = 0;
	int                n_compared = 0;
	int                cyc = 0;
	row_s              rows [6];

	always #50 clk = ~clk;

	match_capture_counter_timer #(.WIDTH(16)) dut
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.addr      (addr),
		.wdata     (wdata),
		.wr        (wr),
		.rd        (rd),
		.rdata     (rdata),
		.cap_in    (cap_in),
		.match_out (match_out),
		.irq       (irq)
	);

	pin_side u_pins
	(
		.clk    (clk),
		.cap_in (cap_in)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		rows[0] = '{OFS_PRESC, 32'h0001_2345, 32'h0000_2345};
		rows[1] = '{OFS_COUNT, 32'habcd_1234, 32'h0000_1234};
		rows[2] = '{OFS_MATCH0 + 8'h0c, 32'hffff_ffff, 32'h0000_ffff};
		rows[3] = '{OFS_CAP0, 32'h0000_1234, 32'h0000_0000};
		rows[4] = '{8'hfc, 32'h0000_ffff, 32'h0000_0000};
		rows[5] = '{OFS_IRQ_MASK, 32'h0000_00ff, 32'h0000_003f};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({30'h0, irq, |match_out}, 32'h0);
		rd_reg(OFS_CTRL, d);
		chk(d, 32'h0);
		foreach (rows[i])
		begin
			wr_reg(rows[i].a, rows[i].w);
			rd_reg(rows[i].a, d);
			chk(d, rows[i].e);
		end
		// prescaled run stopping at match 0 with toggle and interrupt
		wr_reg(OFS_IRQ_MASK, 32'h0);
		wr_reg(OFS_COUNT, 32'h0);
		wr_reg(OFS_PRESC, 32'h1);
		wr_reg(OFS_MATCH0, 32'h5);
		wr_reg(OFS_MCTRL, 32'h5);
		wr_reg(OFS_EMCTRL, 32'h3);
		wr_reg(OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h2);
		repeat (40) @(posedge clk);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h5);
		rd_reg(OFS_CTRL, d);
		chk(d, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({28'h0, match_out}, 32'h1);
		wr_reg(OFS_IRQ_MASK, 32'h1);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		rd_reg(OFS_IRQ_STAT, d);
		chk(d, 32'h1);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		// reset on match 1, low and high output actions
		wr_reg(OFS_MCTRL, 32'h10);
		wr_reg(OFS_MATCH0, 32'h2);
		wr_reg(OFS_MATCH0 + 8'h04, 32'h3);
		wr_reg(OFS_EMOUT, 32'h9);
		wr_reg(OFS_EMCTRL, 32'h9);
		wr_reg(OFS_COUNT, 32'h0);
		wr_reg(OFS_PRESC, 32'h0);
		wr_reg(OFS_CTRL, 32'h1);
		repeat (30) @(posedge clk);
		rd_reg(OFS_COUNT, d);
		chk({31'h0, d < 32'h4}, 32'h1);
		chk({28'h0, match_out}, 32'ha);
		wr_reg(OFS_CTRL, 32'h3);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h0);
		rd_reg(OFS_PCNT, d);
		chk(d, 32'h0);
		// pulse width: ch0 rise clears, ch1 fall captures
		wr_reg(OFS_MCTRL, 32'h0);
		wr_reg(OFS_IRQ_MASK, 32'h10);
		wr_reg(OFS_CCTRL, 32'h55);
		wr_reg(OFS_CTRL, 32'h1);
		rd_reg(OFS_IRQ_STAT, d);
		u_pins.pulse(2'b11, 20, 0);
		chk({31'h0, irq}, 32'h1);
		rd_reg(OFS_CAP0 + 8'h04, d);
		chk({31'h0, d >= 32'd19 && d <= 32'd21}, 32'h1);
		rd_reg(OFS_IRQ_STAT, d);
		chk(d, 32'h10);
		// event counting on rising edges of pin 1, prompt and slow
		wr_reg(OFS_CCTRL, 32'h0);
		wr_reg(OFS_CTRL, 32'h2d);
		wr_reg(OFS_COUNT, 32'h0);
		u_pins.pulse(2'b10, 2, 0);
		u_pins.pulse(2'b10, 3, 5);
		u_pins.pulse(2'b10, 1, 9);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h3);
		// event counting on falling edges of pin 0 only
		wr_reg(OFS_CTRL, 32'h15);
		wr_reg(OFS_COUNT, 32'h0);
		u_pins.pulse(2'b01, 2, 0);
		u_pins.pulse(2'b10, 4, 3);
		u_pins.pulse(2'b01, 1, 2);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h2);
		// mid-run reset clears outputs and registers
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({28'h0, match_out}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(OFS_COUNT, d);
		chk(d, 32'h0);
		rd_reg(OFS_CTRL, d);
		chk(d, 32'h0);
		print_verdict();
	end
endmodule
